// [rtl/vbi2c_params.svh]
// constants of the video buffer serial control port
`ifndef VBI2C_PARAMS_SVH
`define VBI2C_PARAMS_SVH

// fixed upper address bits, binary 01011
`define VB_ADDR_FIXED   5'h0b
// subaddress range: three channel registers then the sync and global register
`define VB_SUB_FIRST    8'h01
`define VB_SUB_LAST     8'h04
`define VB_SUB_DEFAULT  3'h1
// power-up values: channels ac-bias and monitor enabled with strap high, buffers off with strap low
`define VB_CH_STRAP     8'h04
`define VB_GL_STRAP     8'h40
`define VB_OFF_STATE    8'h00
// byte geometry
`define VB_BIT_LAST     4'h7
`define VB_BIT_ACK      4'h8
// timing: system clock and fast-mode bit period, both in ns; 10000 gives standard mode
`define VB_CLK_NS       8
`define VB_SCL_NS       2500
// quarter bit in system clocks, least time so rounded up
`define VB_QTR          (((`VB_SCL_NS / 4) + `VB_CLK_NS - 1) / `VB_CLK_NS)
`define VB_QTR_W        10

`endif

// [rtl/vbi2c_pkg.sv]
// types shared by both ends of the video buffer serial control port
package vbi2c_pkg;

	typedef enum logic [3:0] {
		VB_S_IDLE = 4'h0,
		VB_S_ADDR = 4'h1,
		VB_S_AACK = 4'h2,
		VB_S_SUB  = 4'h3,
		VB_S_SACK = 4'h4,
		VB_S_WDAT = 4'h5,
		VB_S_WACK = 4'h6,
		VB_S_RDAT = 4'h7,
		VB_S_RACK = 4'h8,
		VB_S_WAIT = 4'h9
	} vbi2c_sst_t;

	typedef enum logic [1:0] {
		VB_M_IDLE  = 2'h0,
		VB_M_START = 2'h1,
		VB_M_BIT   = 2'h2,
		VB_M_STOP  = 2'h3
	} vbi2c_mst_t;

	// master transfer kinds
	typedef enum logic [1:0] {
		VB_K_WRITE  = 2'h0,
		VB_K_SELECT = 2'h1,
		VB_K_READ   = 2'h2
	} vbi2c_kind_t;

endpackage : vbi2c_pkg

// [rtl/vbi2c_if.sv]
// two-wire bus between the bus master and the video buffer control port
`timescale 1ns/10ps
interface vbi2c_if;
	logic scl_m_o;
	logic scl_m_oe;
	logic sda_m_o;
	logic sda_m_oe;
	logic sda_s_o;
	logic sda_s_oe;
	logic scl;
	logic sda;

	// open drain with pull-ups: low when any enabled driver pulls low
	assign scl = ~(scl_m_oe & ~scl_m_o);
	assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));

	modport master (output scl_m_o, output scl_m_oe, output sda_m_o, output sda_m_oe, input scl, input sda);
	modport slave  (output sda_s_o, output sda_s_oe, input scl, input sda);
endinterface : vbi2c_if

// [rtl/vbi2c_slave.sv]
// video buffer serial control port, device end
// Function
// - master starts; device detects start anytime
// - master sends 7-bit address plus direction
// - SDA changes only while SCL low
// - acknowledge only own address, else release
// - stop releases bus, device goes idle
// - master releases SDA during write acks
// - no write bursts; extra bytes ignored
// - master acks, ends read with nack
// - read returns only a single byte
// - first byte after start is address
// - upper five address bits are 01011
// - address bits follow select pins live
// - works at 100 and 400 kbps
// - master alone drives SCL and conditions
// - SDA only driven low or released
// - write is address, subaddress, one data
// - subaddresses 1..3 channels, 4 global
// - read returns selected subaddress register
// - strap sets power-up state until write
`timescale 1ns/10ps
`include "vbi2c_params.svh"
module vbi2c_slave
	import vbi2c_pkg::*;
(
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        nrst_i,
	// bus side
	vbi2c_if.slave           bus,
	// device pins
	input  wire logic        addr_select_high_pin_i,
	input  wire logic        addr_select_low_pin_i,
	input  wire logic        power_up_state_strap_i,
	// register contents, subaddress 4 in the top byte
	output logic [31:0]      cfg_o,
	output logic             wr_stb_o
);

	////////////////////////////////////////////////////////////////////////
	// helpers

	// own address check, select pins are never latched
	function automatic logic addr_match(input logic [7:0] b, input logic hi, input logic lo);
		addr_match = (b[7:3] == `VB_ADDR_FIXED) && (b[2] == hi) && (b[1] == lo);
	endfunction : addr_match

	function automatic logic [1:0] sub_index(input logic [2:0] s);
		sub_index = 2'(s - `VB_SUB_DEFAULT);
	endfunction : sub_index

	////////////////////////////////////////////////////////////////////////
	// input synchronisers, two flops before any logic

	logic        scl_s1_r, scl_s2_r, scl_d_r;
	logic        sda_s1_r, sda_s2_r, sda_d_r;
	logic        ahi_s1_r, ahi_s2_r;
	logic        alo_s1_r, alo_s2_r;
	logic        pu_s1_r,  pu_s2_r;

	// idle bus reads high, so the line flops reset high
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			scl_s1_r <= 1'b1;
			scl_s2_r <= 1'b1;
			scl_d_r  <= 1'b1;
			sda_s1_r <= 1'b1;
			sda_s2_r <= 1'b1;
			sda_d_r  <= 1'b1;
			ahi_s1_r <= 1'b0;
			ahi_s2_r <= 1'b0;
			alo_s1_r <= 1'b0;
			alo_s2_r <= 1'b0;
			pu_s1_r  <= 1'b0;
			pu_s2_r  <= 1'b0;
		end
		else
		begin
			scl_s1_r <= bus.scl;  // three-clock lag, far below a fast-mode quarter bit
			scl_s2_r <= scl_s1_r;
			scl_d_r  <= scl_s2_r;
			sda_s1_r <= bus.sda;
			sda_s2_r <= sda_s1_r;
			sda_d_r  <= sda_s2_r;
			ahi_s1_r <= addr_select_high_pin_i;
			ahi_s2_r <= ahi_s1_r;
			alo_s1_r <= addr_select_low_pin_i;
			alo_s2_r <= alo_s1_r;
			pu_s1_r  <= power_up_state_strap_i;
			pu_s2_r  <= pu_s1_r;
		end
	end

	// bus events, all from the second stage onward
	logic scl_rise, scl_fall, start_det, stop_det;
	assign scl_rise  = scl_s2_r & ~scl_d_r;
	assign scl_fall  = ~scl_s2_r & scl_d_r;
	assign start_det = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
	assign stop_det  = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;

	////////////////////////////////////////////////////////////////////////
	// protocol engine

	vbi2c_sst_t  st_r, st_nxt;
	logic [3:0]  cnt_r, cnt_nxt;
	logic [7:0]  sh_r, sh_nxt;
	logic        rw_r, rw_nxt;
	logic        oe_r, oe_nxt;
	logic [2:0]  sel_r, sel_nxt;
	logic        wr_r, wr_nxt;
	logic [7:0]  regs_r [0:3];
	logic [7:0]  regs_nxt [0:3];
	logic        written_r, written_nxt;
	logic        sda_lo_r;

	always_comb
	begin
		st_nxt  = st_r;
		cnt_nxt = cnt_r;
		sh_nxt  = sh_r;
		rw_nxt  = rw_r;
		oe_nxt  = oe_r;
		sel_nxt = sel_r;
		wr_nxt  = 1'b0;
		if (start_det)
		begin
			// restart is legal in any state; next byte is the address
			st_nxt  = VB_S_ADDR;
			cnt_nxt = 4'h0;
			oe_nxt  = 1'b0;
		end
		else if (stop_det)
		begin
			st_nxt = VB_S_IDLE;
			oe_nxt = 1'b0;
		end
		else
		begin
			case (st_r)
				VB_S_ADDR, VB_S_SUB, VB_S_WDAT:
				begin
					// sample on rise, act on the fall after the eighth bit
					if (scl_rise)
					begin
						sh_nxt  = {sh_r[6:0], sda_s2_r};
						cnt_nxt = 4'(cnt_r + 4'h1);
					end
					if (scl_fall && (cnt_r == `VB_BIT_ACK))
					begin
						cnt_nxt = 4'h0;
						case (st_r)
							VB_S_ADDR:
							begin
								if (addr_match(sh_r, ahi_s2_r, alo_s2_r))
								begin
									st_nxt = VB_S_AACK;
									oe_nxt = 1'b1;
									rw_nxt = sh_r[0];
								end
								else
									st_nxt = VB_S_WAIT;
							end
							VB_S_SUB:
							begin
								// only mapped subaddresses are acknowledged
								if ((sh_r >= `VB_SUB_FIRST) && (sh_r <= `VB_SUB_LAST))
								begin
									sel_nxt = sh_r[2:0];
									st_nxt  = VB_S_SACK;
									oe_nxt  = 1'b1;
								end
								else
									st_nxt = VB_S_WAIT;
							end
							default:
							begin
								st_nxt = VB_S_WACK;
								oe_nxt = 1'b1;
								wr_nxt = 1'b1;
							end
						endcase
					end
				end
				VB_S_AACK:
				begin
					// ack held through the whole ninth high phase
					if (scl_fall)
					begin
						cnt_nxt = 4'h0;
						if (rw_r)
						begin
							st_nxt = VB_S_RDAT;
							sh_nxt = regs_r[sub_index(sel_r)];
							oe_nxt = ~regs_r[sub_index(sel_r)][7];
						end
						else
						begin
							st_nxt = VB_S_SUB;
							oe_nxt = 1'b0;
						end
					end
				end
				VB_S_SACK:
				begin
					if (scl_fall)
					begin
						st_nxt = VB_S_WDAT;
						oe_nxt = 1'b0;
					end
				end
				VB_S_WACK:
				begin
					// further bytes are left unacknowledged and dropped
					if (scl_fall)
					begin
						st_nxt = VB_S_WAIT;
						oe_nxt = 1'b0;
					end
				end
				VB_S_RDAT:
				begin
					// next bit goes out only after the falling edge
					if (scl_fall)
					begin
						cnt_nxt = 4'(cnt_r + 4'h1);
						if (cnt_r == `VB_BIT_LAST)
						begin
							st_nxt = VB_S_RACK;
							oe_nxt = 1'b0;
						end
						else
						begin
							sh_nxt = {sh_r[6:0], 1'b0};
							oe_nxt = ~sh_r[6];
						end
					end
				end
				VB_S_RACK:
				begin
					// one byte only, whatever the master answers
					if (scl_fall)
						st_nxt = VB_S_WAIT;
				end
				default:
					oe_nxt = 1'b0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register file, follows the strap until the first completed write

	always_comb
	begin
		written_nxt = written_r;
		for (int i = 0; i < 4; i++)
		begin
			regs_nxt[i] = regs_r[i];
			if (!written_r)
				regs_nxt[i] = pu_s2_r ? ((i == 3) ? `VB_GL_STRAP : `VB_CH_STRAP) : `VB_OFF_STATE;
		end
		if (wr_nxt)
		begin
			regs_nxt[sub_index(sel_r)] = sh_r;
			written_nxt                = 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			st_r      <= VB_S_IDLE;
			cnt_r     <= 4'h0;
			sh_r      <= 8'h00;
			rw_r      <= 1'b0;
			oe_r      <= 1'b0;
			sel_r     <= `VB_SUB_DEFAULT;
			wr_r      <= 1'b0;
			written_r <= 1'b0;
			sda_lo_r  <= 1'b0;
			for (int i = 0; i < 4; i++)
				regs_r[i] <= `VB_OFF_STATE;
		end
		else
		begin
			st_r      <= st_nxt;
			cnt_r     <= cnt_nxt;
			sh_r      <= sh_nxt;
			rw_r      <= rw_nxt;
			oe_r      <= oe_nxt;
			sel_r     <= sel_nxt;
			wr_r      <= wr_nxt;
			written_r <= written_nxt;
			sda_lo_r  <= 1'b0;
			for (int i = 0; i < 4; i++)
				regs_r[i] <= regs_nxt[i];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs, SCL is never driven by this end

	assign bus.sda_s_o  = sda_lo_r;
	assign bus.sda_s_oe = oe_r;
	assign cfg_o        = {regs_r[3], regs_r[2], regs_r[1], regs_r[0]};
	assign wr_stb_o     = wr_r;

endmodule : vbi2c_slave

// [rtl/vbi2c_master.sv]
// bus master end driving the video buffer control port
`timescale 1ns/10ps
`include "vbi2c_params.svh"
module vbi2c_master
	import vbi2c_pkg::*;
(
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        nrst_i,
	// bus side
	vbi2c_if.master          bus,
	// request
	input  wire logic        req_i,
	input  vbi2c_kind_t      kind_i,
	input  wire logic [6:0]  dev_addr_i,
	input  wire logic [7:0]  sub_i,
	input  wire logic [7:0]  wdata_i,
	// answer
	output logic             busy_o,
	output logic             done_o,
	output logic             nack_o,
	output logic [7:0]       rdata_o
);

	////////////////////////////////////////////////////////////////////////
	// SDA input synchroniser

	logic sda_s1_r, sda_s2_r;
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			sda_s1_r <= 1'b1;
			sda_s2_r <= 1'b1;
		end
		else
		begin
			sda_s1_r <= bus.sda;
			sda_s2_r <= sda_s1_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// quarter-bit sequencer; SCL made here by division

	vbi2c_mst_t           st_r, st_nxt;
	logic [`VB_QTR_W-1:0] q_r, q_nxt;
	logic [1:0]           ph_r, ph_nxt;
	logic [3:0]           bit_r, bit_nxt;
	logic [1:0]           byi_r, byi_nxt;
	logic [1:0]           nb_r, nb_nxt;
	logic                 rd_r, rd_nxt;
	logic [7:0]           tx_r [0:2];
	logic [7:0]           tx_nxt [0:2];
	logic                 scl_oe_r, scl_oe_nxt;
	logic                 sda_oe_r, sda_oe_nxt;
	logic                 busy_r, busy_nxt;
	logic                 done_r, done_nxt;
	logic                 nack_r, nack_nxt;
	logic [7:0]           rdat_r, rdat_nxt;
	logic                 lo_r;
	logic                 tick, reading, last_byte, bitval;

	assign tick      = (q_r == `VB_QTR_W'(`VB_QTR - 1));
	assign last_byte = (byi_r == 2'(nb_r - 2'h1));
	assign reading   = rd_r & last_byte;
	// reads leave SDA released for data and for the closing nack
	assign bitval    = (reading || (bit_r == `VB_BIT_ACK)) ? 1'b1 : tx_r[byi_r][3'(`VB_BIT_LAST - bit_r)];

	always_comb
	begin
		st_nxt     = st_r;
		q_nxt      = tick ? '0 : `VB_QTR_W'(q_r + 1'b1);
		ph_nxt     = tick ? 2'(ph_r + 2'h1) : ph_r;
		bit_nxt    = bit_r;
		byi_nxt    = byi_r;
		nb_nxt     = nb_r;
		rd_nxt     = rd_r;
		scl_oe_nxt = scl_oe_r;
		sda_oe_nxt = sda_oe_r;
		busy_nxt   = busy_r;
		done_nxt   = 1'b0;
		nack_nxt   = nack_r;
		rdat_nxt   = rdat_r;
		for (int i = 0; i < 3; i++)
			tx_nxt[i] = tx_r[i];
		case (st_r)
			VB_M_IDLE:
			begin
				q_nxt      = '0;
				ph_nxt     = 2'h0;
				scl_oe_nxt = 1'b0;
				sda_oe_nxt = 1'b0;
				if (req_i)
				begin
					st_nxt    = VB_M_START;
					busy_nxt  = 1'b1;
					nack_nxt  = 1'b0;
					rd_nxt    = (kind_i == VB_K_READ);
					nb_nxt    = (kind_i == VB_K_WRITE) ? 2'h3 : 2'h2;
					tx_nxt[0] = {dev_addr_i, (kind_i == VB_K_READ)};
					tx_nxt[1] = sub_i;
					tx_nxt[2] = wdata_i;
				end
			end
			VB_M_START:
			begin
				if (tick)
				begin
					case (ph_r)
						2'h0: sda_oe_nxt = 1'b0;
						2'h1: sda_oe_nxt = 1'b1;   // falls while SCL high
						2'h2: scl_oe_nxt = 1'b1;
						default:
						begin
							st_nxt  = VB_M_BIT;
							bit_nxt = 4'h0;
							byi_nxt = 2'h0;
						end
					endcase
				end
			end
			VB_M_BIT:
			begin
				if (tick)
				begin
					case (ph_r)
						2'h0: sda_oe_nxt = ~bitval;
						2'h1: scl_oe_nxt = 1'b0;
						2'h2:
						begin
							if (reading && (bit_r != `VB_BIT_ACK))
								rdat_nxt = {rdat_r[6:0], sda_s2_r};
							if (!reading && (bit_r == `VB_BIT_ACK) && sda_s2_r)
								nack_nxt = 1'b1;
						end
						default:
						begin
							scl_oe_nxt = 1'b1;
							bit_nxt    = 4'(bit_r + 4'h1);
							if (bit_r == `VB_BIT_ACK)
							begin
								bit_nxt = 4'h0;
								byi_nxt = 2'(byi_r + 2'h1);
								if (last_byte || nack_r)
									st_nxt = VB_M_STOP;
							end
						end
					endcase
				end
			end
			default:
			begin
				if (tick)
				begin
					case (ph_r)
						2'h0: sda_oe_nxt = 1'b1;
						2'h1: scl_oe_nxt = 1'b0;
						2'h2: sda_oe_nxt = 1'b0;   // rises while SCL high
						default:
						begin
							st_nxt   = VB_M_IDLE;
							busy_nxt = 1'b0;
							done_nxt = 1'b1;
						end
					endcase
				end
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			st_r     <= VB_M_IDLE;
			q_r      <= '0;
			ph_r     <= 2'h0;
			bit_r    <= 4'h0;
			byi_r    <= 2'h0;
			nb_r     <= 2'h0;
			rd_r     <= 1'b0;
			scl_oe_r <= 1'b0;
			sda_oe_r <= 1'b0;
			busy_r   <= 1'b0;
			done_r   <= 1'b0;
			nack_r   <= 1'b0;
			rdat_r   <= 8'h00;
			lo_r     <= 1'b0;
			for (int i = 0; i < 3; i++)
				tx_r[i] <= 8'h00;
		end
		else
		begin
			st_r     <= st_nxt;
			q_r      <= q_nxt;
			ph_r     <= ph_nxt;
			bit_r    <= bit_nxt;
			byi_r    <= byi_nxt;
			nb_r     <= nb_nxt;
			rd_r     <= rd_nxt;
			scl_oe_r <= scl_oe_nxt;
			sda_oe_r <= sda_oe_nxt;
			busy_r   <= busy_nxt;
			done_r   <= done_nxt;
			nack_r   <= nack_nxt;
			rdat_r   <= rdat_nxt;
			lo_r     <= 1'b0;
			for (int i = 0; i < 3; i++)
				tx_r[i] <= tx_nxt[i];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs, open drain: only ever pull low

	assign bus.scl_m_o  = lo_r;
	assign bus.scl_m_oe = scl_oe_r;
	assign bus.sda_m_o  = lo_r;
	assign bus.sda_m_oe = sda_oe_r;
	assign busy_o       = busy_r;
	assign done_o       = done_r;
	assign nack_o       = nack_r;
	assign rdata_o      = rdat_r;

endmodule : vbi2c_master

// [testbench/vbi2c_props.sv]
// concurrent checks on the two-wire bus between master and device ends
`timescale 1ns/10ps
`include "vbi2c_params.svh"
module vbi2c_props
	import vbi2c_pkg::*;
(
	// clock and reset
	input  wire logic clk_i,
	input  wire logic nrst_i,
	// driver halves of the wires
	input  wire logic scl_m_o,
	input  wire logic scl_m_oe,
	input  wire logic sda_m_o,
	input  wire logic sda_m_oe,
	input  wire logic sda_s_o,
	input  wire logic sda_s_oe,
	// resolved wires
	input  wire logic scl,
	input  wire logic sda
);
	logic       scl_q_r, scl_q_nxt, sda_q_r, sda_q_nxt, rd_r, rd_nxt, ackd_r, ackd_nxt;
	logic [3:0] bit_r, bit_nxt;
	logic [1:0] byte_r, byte_nxt;
	logic [7:0] shift_r, shift_nxt;
	logic       start_w, stop_w, rise_w, sub_ok_w;

	////////////////////////////////////////////////////////////////////////
	// bus events seen one clock late, same as any sampling receiver
	assign start_w  = scl_q_r & scl & sda_q_r & ~sda;
	assign stop_w   = scl_q_r & scl & ~sda_q_r & sda;
	assign rise_w   = scl & ~scl_q_r;
	assign sub_ok_w = (shift_r >= `VB_SUB_FIRST) && (shift_r <= `VB_SUB_LAST);

	// bit and byte position; shift skips the ack bit so it holds the byte
	always_comb
	begin
		{scl_q_nxt, sda_q_nxt} = {scl, sda};
		{bit_nxt, byte_nxt, shift_nxt, rd_nxt, ackd_nxt} = {bit_r, byte_r, shift_r, rd_r, ackd_r};
		if (start_w)
		begin
			{bit_nxt, byte_nxt, ackd_nxt} = {4'h0, 2'h0, 1'b0};
		end
		else if (rise_w && bit_r == 4'h9)
		begin
			bit_nxt   = 4'h1;
			byte_nxt  = (byte_r == 2'h3) ? 2'h3 : byte_r + 2'h1; // saturate, only 0..2 matter
			shift_nxt = {shift_r[6:0], sda};
		end
		else if (rise_w)
		begin
			bit_nxt = bit_r + 4'h1;
			if (bit_r != 4'h8)
				shift_nxt = {shift_r[6:0], sda};
			if (bit_r == 4'h8 && byte_r == 2'h0)
				rd_nxt = shift_r[0];
		end
		if (scl && bit_r == 4'h9 && byte_r == 2'h0 && sda_s_oe)
			ackd_nxt = 1'b1;
	end

	// registers only
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			{scl_q_r, sda_q_r, bit_r, byte_r, shift_r, rd_r, ackd_r} <= {2'h3, 4'h0, 2'h3, 8'h00, 2'h0};
		else
			{scl_q_r, sda_q_r, bit_r, byte_r, shift_r, rd_r, ackd_r} <=
				{scl_q_nxt, sda_q_nxt, bit_nxt, byte_nxt, shift_nxt, rd_nxt, ackd_nxt};
	end

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);

	// settled high phase only: on the rise edge itself the count still shows the old slot
	sequence ack_slot_s;
		scl && scl_q_r && bit_r == 4'h9;
	endsequence
	sequence sub_done_s;
		$fell(scl) && bit_r == 4'h8 && byte_r == 2'h1 && !rd_r;
	endsequence

	drain_only_a : assert property (!(sda_s_oe && sda_s_o) && !(sda_m_oe && sda_m_o) && !(scl_m_oe && scl_m_o))
		else $error("a wire driven high");
	sda_hold_a : assert property (scl && scl_q_r |-> $stable(sda_s_oe))
		else $error("device moved sda with scl high");
	addr_fixed_a : assert property (ack_slot_s ##0 (byte_r == 2'h0 && sda_s_oe) |-> shift_r[7:3] == `VB_ADDR_FIXED)
		else $error("device acked a foreign address");
	bus_free_a : assert property (stop_w |=> !sda_s_oe [*8])
		else $error("device holds sda after stop");
	wr_release_a : assert property (ack_slot_s ##0 (byte_r == 2'h0 || !rd_r) |-> !sda_m_oe)
		else $error("master drives a write ack slot");
	rd_single_a : assert property (scl && rd_r && ((byte_r == 2'h1 && bit_r == 4'h9) || byte_r > 2'h1) |-> !sda_s_oe)
		else $error("device sends past one read byte");
	rd_nack_a : assert property (ack_slot_s ##0 (rd_r && byte_r == 2'h1) |-> !sda_m_oe)
		else $error("master acked the single read byte");
	sub_ack_a : assert property (sub_done_s |-> ##[1:8] (sda_s_oe == (ackd_r && sub_ok_w)))
		else $error("subaddress ack wrong");
endmodule : vbi2c_props

// [testbench/test_vbi2c.sv]
// self-checking bench: master end driving the device end over the bus
`timescale 1ns/10ps
`include "vbi2c_params.svh"
module test_vbi2c
	import vbi2c_pkg::*;
;
	localparam int LIMIT = 60000; // seven transfers at 400 kbps need about 45000 clocks
	logic        clk_i, nrst_i, req_i, pin_hi, pin_lo, strap;
	vbi2c_kind_t kind_i;
	logic [6:0]  dev_addr_i;
	logic [7:0]  sub_i, wdata_i, rdata_o;
	logic        busy_o, done_o, nack_o, wr_stb_o;
	logic [31:0] cfg_o;
	int          err_total, checked, cyc, stb_cnt;

	////////////////////////////////////////////////////////////////////////
	vbi2c_if vbi2c_if_inst ();
	vbi2c_master vbi2c_master_inst (.clk_i(clk_i), .nrst_i(nrst_i), .bus(vbi2c_if_inst.master), .req_i(req_i),
		.kind_i(kind_i), .dev_addr_i(dev_addr_i), .sub_i(sub_i), .wdata_i(wdata_i), .busy_o(busy_o),
		.done_o(done_o), .nack_o(nack_o), .rdata_o(rdata_o));
	vbi2c_slave vbi2c_slave_inst (.clk_i(clk_i), .nrst_i(nrst_i), .bus(vbi2c_if_inst.slave),
		.addr_select_high_pin_i(pin_hi), .addr_select_low_pin_i(pin_lo), .power_up_state_strap_i(strap),
		.cfg_o(cfg_o), .wr_stb_o(wr_stb_o));
	vbi2c_props vbi2c_props_inst (.clk_i(clk_i), .nrst_i(nrst_i), .scl_m_o(vbi2c_if_inst.scl_m_o),
		.scl_m_oe(vbi2c_if_inst.scl_m_oe), .sda_m_o(vbi2c_if_inst.sda_m_o), .sda_m_oe(vbi2c_if_inst.sda_m_oe),
		.sda_s_o(vbi2c_if_inst.sda_s_o), .sda_s_oe(vbi2c_if_inst.sda_s_oe), .scl(vbi2c_if_inst.scl),
		.sda(vbi2c_if_inst.sda));

	////////////////////////////////////////////////////////////////////////
	// clock, hang guard and write strobe count
	initial
	begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	always @(posedge clk_i)
	begin
		cyc <= cyc + 1;
		if (wr_stb_o === 1'b1)
			stb_cnt <= stb_cnt + 1;
		if (cyc == LIMIT)
		begin
			err_total = err_total + 1;
			test_done();
		end
	end

	////////////////////////////////////////////////////////////////////////
	task automatic test_done();
		$display("checks %0d, mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : test_done

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked = checked + 1;
		if (got !== exp)
		begin
			err_total = err_total + 1;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// one master request held until the idle edge takes it, then wait for done
	task automatic xfer(input vbi2c_kind_t k, input logic [6:0] a, input logic [7:0] s, input logic [7:0] d);
		int n;
		@(posedge clk_i);
		req_i      <= 1'b1;
		kind_i     <= k;
		dev_addr_i <= a;
		sub_i      <= s;
		wdata_i    <= d;
		@(posedge clk_i);
		req_i <= 1'b0;
		@(negedge clk_i);
		chk({31'h0, busy_o}, 32'h1);
		n = 0;
		do
		begin
			@(negedge clk_i);
			n = n + 1;
		end
		while (done_o !== 1'b1 && n < 40000);
		chk({31'h0, done_o}, 32'h1);
		chk({31'h0, busy_o}, 32'h0);
	endtask : xfer

	task automatic idle(input int n);
		repeat (n) @(posedge clk_i);
		@(negedge clk_i);
	endtask : idle

	////////////////////////////////////////////////////////////////////////
	// main sequence; address pins give bits 2..1 = 2'b10
	initial
	begin
		{err_total, checked, cyc, stb_cnt} = '0;
		{nrst_i, req_i, strap, pin_lo} = 4'h0;
		pin_hi     = 1'b1;
		kind_i     = VB_K_WRITE;
		dev_addr_i = 7'h00;
		sub_i      = 8'h00;
		wdata_i    = 8'h00;
		repeat (3) @(posedge clk_i);
		nrst_i <= 1'b1;
		idle(8);
		chk(cfg_o, {4{`VB_OFF_STATE}});
		@(posedge clk_i);
		strap <= 1'b1;
		idle(8);
		chk(cfg_o, {`VB_GL_STRAP, {3{`VB_CH_STRAP}}});
		// both pin bits wrong: no ack, nothing applied
		xfer(VB_K_WRITE, {`VB_ADDR_FIXED, 2'b01}, 8'h03, 8'h5a);
		chk({31'h0, nack_o}, 32'h1);
		chk(cfg_o, {`VB_GL_STRAP, {3{`VB_CH_STRAP}}});
		// matching address, channel 3 register
		xfer(VB_K_WRITE, {`VB_ADDR_FIXED, 2'b10}, 8'h03, 8'h5a);
		chk({31'h0, nack_o}, 32'h0);
		chk(cfg_o, {`VB_GL_STRAP, 8'h5a, {2{`VB_CH_STRAP}}});
		chk(stb_cnt, 32'h1);
		// strap no longer rules once a write completed
		@(posedge clk_i);
		strap <= 1'b0;
		idle(8);
		chk(cfg_o, {`VB_GL_STRAP, 8'h5a, {2{`VB_CH_STRAP}}});
		// read returns the register last selected by subaddress
		xfer(VB_K_READ, {`VB_ADDR_FIXED, 2'b10}, 8'h00, 8'h00);
		chk({31'h0, nack_o}, 32'h0);
		chk({24'h0, rdata_o}, 32'h5a);
		// subaddress past the map: refused, selection kept
		xfer(VB_K_SELECT, {`VB_ADDR_FIXED, 2'b10}, 8'h05, 8'h00);
		chk({31'h0, nack_o}, 32'h1);
		xfer(VB_K_READ, {`VB_ADDR_FIXED, 2'b10}, 8'h00, 8'h00);
		chk({24'h0, rdata_o}, 32'h5a);
		// sync and global register, selected then read back
		xfer(VB_K_SELECT, {`VB_ADDR_FIXED, 2'b10}, 8'h04, 8'h00);
		chk({31'h0, nack_o}, 32'h0);
		xfer(VB_K_READ, {`VB_ADDR_FIXED, 2'b10}, 8'h00, 8'h00);
		chk({24'h0, rdata_o}, {24'h0, `VB_GL_STRAP});
		chk(stb_cnt, 32'h1);
		test_done();
	end
endmodule : test_vbi2c
